// ### verilog/supervisor_pkg.sv
/*
 * Constants shared by the backlight fault supervisor: register offsets, field positions,
 * reset values, fault timing figures and the shutdown lock states.
 * Assumes a 100 MHz system clock and 8-bit registers.
 */
package supervisor_pkg;

    // System clock and derived microsecond prescale
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US = 1000;
    localparam int CYC_PER_US = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Fault timing, in microseconds
    localparam int OVP_PERSIST_US = 1000;
    localparam int OCP_WINDOW_US = 128;
    localparam int OCP_BLANK_US = 4000;

    // Event thresholds
    localparam int OVP_OCCUR_LIMIT = 3;
    localparam int OCP_DENSITY_MIN = 2;
    localparam int OCP_WINDOWS_NEEDED = 8;

    // Register offsets
    localparam logic [7:0] ADDR_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_BOOST = 8'h13;
    localparam logic [7:0] ADDR_BRT_LSB = 8'h18;
    localparam logic [7:0] ADDR_BRT_MSB = 8'h19;
    localparam logic [7:0] ADDR_FAULT_CTRL = 8'h1E;
    localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h1F;

    // Field positions
    localparam int EN_DEVICE_BIT = 0;
    localparam int EN_STRING_LSB = 1;
    localparam int EN_STRING_MSB = 3;
    localparam int BOOST_OCP_LSB = 0;
    localparam int BOOST_OVP_LSB = 2;
    localparam int FLAG_OVP = 0;
    localparam int FLAG_OCP = 1;
    localparam int FLAG_TSD = 2;
    localparam int FLAG_SHORT = 3;
    localparam int FLAG_OPEN = 4;
    localparam int CTRL_OVP_SD = 0;
    localparam int CTRL_OCP_SD = 1;
    localparam int CTRL_TSD_SD = 2;

    // Reset values and writable masks
    localparam logic [7:0] ENABLE_RST = 8'h0F;
    localparam logic [7:0] ENABLE_MASK = 8'h0F;
    localparam logic [7:0] BOOST_RST = 8'h6F;
    localparam logic [7:0] BOOST_MASK = 8'h7F;
    localparam logic [7:0] BRT_LSB_RST = 8'h07;
    localparam logic [7:0] BRT_LSB_MASK = 8'h07;
    localparam logic [7:0] BRT_MSB_RST = 8'hFF;
    localparam logic [7:0] FAULT_CTRL_RST = 8'h00;
    localparam logic [7:0] FAULT_CTRL_MASK = 8'h07;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // Shutdown lock
    typedef enum logic {LOCK_RUNNING, LOCK_TRIPPED} lock_state_t;

endpackage

// ### verilog/sync_bank.sv
/*
 * Two-stage synchroniser for a bank of asynchronous comparator levels.
 * Assumes the inputs are slow levels; pulses shorter than one clock may be missed.
 */
`timescale 1ns/1ps
module sync_bank #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else if (i_ce)
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

// ### verilog/backlight_fault_supervisor.sv
/*
 * Fault supervisor of a three-string backlight boost driver: gates boost switching,
 * latches fault flags and optionally locks the device off until the flags are read.
 * Assumes comparator levels arrive asynchronously and a register port already decoded
 * from the serial interface, on the same clock as this block.
 */
// Function
// - Boost control bits 3:2 select one of four overvoltage trip levels.
// - Overvoltage stops switching until output drops below threshold minus hysteresis.
// - Overvoltage held over one millisecond sets flag bit 0.
// - Three overvoltage hits with a low sink headroom set bits 0 and 4.
// - Overvoltage over one millisecond with low headroom sets bits 0 and 4.
// - Overvoltage flag shuts down only when fault control bit 0 is set.
// - After a fault shutdown, re-enable is refused until flags are read.
// - Enabled string with supply-to-sink below 1.5 V sets short flag bit 3.
// - Boost control bits 1:0 select one of four switch current limits.
// - Each overcurrent hit turns the low-side switch off for the period.
// - Eight consecutive 128 us windows with two or more hits set overcurrent flag.
// - Overcurrent flag is bit 1 of the fault flag register.
// - Overcurrent hits ignored for 4 ms after start-up and brightness changes.
// - Overcurrent flag shuts down only when fault control bit 1 is set.
// - Overtemperature stops switching and sets thermal flag bit 2.
// - Switching restarts when overtemperature clears, unless thermal shutdown is enabled.
// - Thermal flag shuts down only when fault control bit 2 is set.
// - Enable register: device enable bit 0, string enables bits 3 to 1.
`timescale 1ns/1ps
module backlight_fault_supervisor
    import supervisor_pkg::*;
#(
    parameter int TICK_DIV = supervisor_pkg::CYC_PER_US,
    parameter int OVP_PERSIST = supervisor_pkg::OVP_PERSIST_US,
    parameter int OCP_WINDOW = supervisor_pkg::OCP_WINDOW_US,
    parameter int OCP_BLANK = supervisor_pkg::OCP_BLANK_US
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_ovp_cmp,
    input wire logic [2:0] i_headroom_low,
    input wire logic [2:0] i_short_cmp,
    input wire logic i_ocp_cmp,
    input wire logic i_tsd_cmp,
    input wire logic i_period_start,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_boost_enable,
    output logic o_low_side_switch_off,
    output logic [1:0] o_overvoltage_level,
    output logic [1:0] o_overcurrent_level,
    output logic [2:0] o_string_enable,
    output logic o_device_shutdown
);

    import supervisor_pkg::*;

    localparam int PRE_W = $clog2(TICK_DIV);
    localparam int OVP_W = $clog2(OVP_PERSIST + 1);
    localparam int WIN_W = $clog2(OCP_WINDOW);
    localparam int BLK_W = $clog2(OCP_BLANK + 1);

    // Values the counters cannot serve are refused at elaboration
    generate
        if (TICK_DIV < 2 || OVP_PERSIST < 2 || OCP_WINDOW < 2 || OCP_BLANK < 1)
        begin : g_bad_param
            $error("backlight_fault_supervisor: timing parameter out of range");
        end
    endgenerate

    // Rising edge of a level against its previous sample
    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    // Saturating two-bit increment
    function automatic logic [1:0] sat_inc(input logic [1:0] v, input logic en);
        return (en && v != 2'h3) ? v + 2'h1 : v;
    endfunction

    logic [8:0] sync_out;
    logic ovp_s;
    logic ocp_s;
    logic tsd_s;
    logic [2:0] hr_s;
    logic [2:0] sh_s;
    logic ovp_d_r;
    logic ocp_d_r;
    logic tsd_d_r;
    logic en_d_r;
    logic [PRE_W-1:0] pre_cnt_r;
    logic us_tick;
    logic [7:0] enable_r;
    logic [7:0] boost_r;
    logic [7:0] brt_lsb_r;
    logic [7:0] brt_msb_r;
    logic [7:0] ctrl_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] set_vec;
    logic [7:0] rdata_r;
    lock_state_t lock_r;
    lock_state_t lock_nxt;
    logic dev_en;
    logic hr_low_any;
    logic short_any;
    logic flag_rd;
    logic en_wr;
    logic brt_change;
    logic [OVP_W-1:0] ovp_cnt_r;
    logic ovp_long_evt;
    logic [1:0] occ_cnt_r;
    logic occ_evt;
    logic set_ovp;
    logic set_open;
    logic [BLK_W-1:0] blank_cnt_r;
    logic blanking;
    logic ocp_evt;
    logic [WIN_W-1:0] win_cnt_r;
    logic win_end;
    logic [1:0] dens_r;
    logic [1:0] dens_now;
    logic [3:0] consec_r;
    logic set_ocp;
    logic set_tsd;
    logic set_short;
    logic trip;
    logic gate_r;
    logic sw_off_r;
    logic shutdown_r;

    // Comparator levels are asynchronous to the clock
    sync_bank #(
        .WIDTH(9)
    ) u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_async({i_ovp_cmp, i_ocp_cmp, i_tsd_cmp, i_headroom_low, i_short_cmp}),
        .o_sync(sync_out)
    );

    assign ovp_s = sync_out[8];
    assign ocp_s = sync_out[7];
    assign tsd_s = sync_out[6];
    assign hr_s = sync_out[5:3];
    assign sh_s = sync_out[2:0];

    // Previous samples for edge detection
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ovp_d_r <= 1'b0;
            ocp_d_r <= 1'b0;
            tsd_d_r <= 1'b0;
            en_d_r <= 1'b0;
        end
        else if (i_ce)
        begin
            ovp_d_r <= ovp_s;
            ocp_d_r <= ocp_s;
            tsd_d_r <= tsd_s;
            en_d_r <= dev_en;
        end
    end

    // Microsecond prescaler; all long intervals count these ticks, not raw cycles
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            pre_cnt_r <= '0;
        else if (i_ce)
            pre_cnt_r <= us_tick ? '0 : pre_cnt_r + 1'b1;
    end

    assign us_tick = (pre_cnt_r == PRE_W'(TICK_DIV - 1));

    // Decoded register strobes and shared conditions
    assign flag_rd = i_reg_rd && i_reg_addr == ADDR_FAULT_FLAGS;
    assign en_wr = i_reg_wr && i_reg_addr == ADDR_ENABLE;
    assign brt_change = i_reg_wr && ((i_reg_addr == ADDR_BRT_LSB && (i_reg_wdata & BRT_LSB_MASK) != brt_lsb_r)
                        || (i_reg_addr == ADDR_BRT_MSB && i_reg_wdata != brt_msb_r));
    assign dev_en = enable_r[EN_DEVICE_BIT];
    assign hr_low_any = dev_en && |(hr_s & enable_r[EN_STRING_MSB:EN_STRING_LSB]);
    assign short_any = dev_en && |(sh_s & enable_r[EN_STRING_MSB:EN_STRING_LSB]);

    // Enable register; a trip drops the device enable and a lock refuses setting it again
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            enable_r <= ENABLE_RST;
        else if (i_ce)
        begin
            if (trip)
                enable_r[EN_DEVICE_BIT] <= 1'b0;
            else if (en_wr)
            begin
                enable_r <= i_reg_wdata & ENABLE_MASK;
                if (lock_r == LOCK_TRIPPED && !flag_rd)
                    enable_r[EN_DEVICE_BIT] <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            boost_r <= BOOST_RST;
            brt_lsb_r <= BRT_LSB_RST;
            brt_msb_r <= BRT_MSB_RST;
            ctrl_r <= FAULT_CTRL_RST;
        end
        else if (i_ce && i_reg_wr)
        begin
            case (i_reg_addr)
                ADDR_BOOST: boost_r <= i_reg_wdata & BOOST_MASK;
                ADDR_BRT_LSB: brt_lsb_r <= i_reg_wdata & BRT_LSB_MASK;
                ADDR_BRT_MSB: brt_msb_r <= i_reg_wdata;
                ADDR_FAULT_CTRL: ctrl_r <= i_reg_wdata & FAULT_CTRL_MASK;
                default: ;
            endcase
        end
    end

    // Overvoltage persistence timer, in microseconds while the comparator stays high
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            ovp_cnt_r <= '0;
        else if (i_ce)
        begin
            if (!ovp_s)
                ovp_cnt_r <= '0;
            else if (us_tick && ovp_cnt_r != OVP_W'(OVP_PERSIST))
                ovp_cnt_r <= ovp_cnt_r + 1'b1;
        end
    end

    assign ovp_long_evt = ovp_s && us_tick && ovp_cnt_r == OVP_W'(OVP_PERSIST - 1);

    // Overvoltage occurrences with a starved sink; restarts after the flags are read
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            occ_cnt_r <= 2'h0;
        else if (i_ce)
        begin
            if (flag_rd)
                occ_cnt_r <= 2'h0;
            else
                occ_cnt_r <= sat_inc(occ_cnt_r, rise(ovp_s, ovp_d_r) && hr_low_any);
        end
    end

    assign occ_evt = rise(ovp_s, ovp_d_r) && hr_low_any && occ_cnt_r == 2'(OVP_OCCUR_LIMIT - 1);
    assign set_open = occ_evt || (ovp_long_evt && hr_low_any);
    assign set_ovp = ovp_long_evt || set_open;

    // Overcurrent blanking after start-up and brightness changes
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            blank_cnt_r <= '0;
        else if (i_ce)
        begin
            if (rise(dev_en, en_d_r) || brt_change)
                blank_cnt_r <= BLK_W'(OCP_BLANK);
            else if (us_tick && blanking)
                blank_cnt_r <= blank_cnt_r - 1'b1;
        end
    end

    assign blanking = (blank_cnt_r != '0);
    assign ocp_evt = rise(ocp_s, ocp_d_r) && !blanking && dev_en;

    // Pulse density over fixed windows; a window with fewer than two hits breaks the run
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            win_cnt_r <= '0;
            dens_r <= 2'h0;
            consec_r <= 4'h0;
        end
        else if (i_ce)
        begin
            if (us_tick)
                win_cnt_r <= win_end ? '0 : win_cnt_r + 1'b1;
            if (win_end)
            begin
                dens_r <= 2'h0;
                if (set_ocp || dens_now < 2'(OCP_DENSITY_MIN))
                    consec_r <= 4'h0;
                else
                    consec_r <= consec_r + 4'h1;
            end
            else
                dens_r <= dens_now;
        end
    end

    assign win_end = us_tick && win_cnt_r == WIN_W'(OCP_WINDOW - 1);
    assign dens_now = sat_inc(dens_r, ocp_evt);
    assign set_ocp = win_end && dens_now >= 2'(OCP_DENSITY_MIN)
                     && consec_r == 4'(OCP_WINDOWS_NEEDED - 1);

    assign set_tsd = rise(tsd_s, tsd_d_r);
    assign set_short = short_any;

    // Flag sources, placed at their bit positions
    always_comb
    begin
        set_vec = FLAGS_RST;
        set_vec[FLAG_OVP] = set_ovp;
        set_vec[FLAG_OCP] = set_ocp;
        set_vec[FLAG_TSD] = set_tsd;
        set_vec[FLAG_SHORT] = set_short;
        set_vec[FLAG_OPEN] = set_open;
    end

    // Sticky flags: a read clears them, but a fault in the same cycle still lands
    assign flags_nxt = (flag_rd ? FLAGS_RST : flags_r) | set_vec;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            flags_r <= FLAGS_RST;
        else if (i_ce)
            flags_r <= flags_nxt;
    end

    // A flag trips shutdown only when its control bit asks for it
    assign trip = (set_ovp && ctrl_r[CTRL_OVP_SD])
                  || (set_ocp && ctrl_r[CTRL_OCP_SD])
                  || (set_tsd && ctrl_r[CTRL_TSD_SD]);

    // Shutdown lock
    always_comb
    begin
        lock_nxt = lock_r;
        case (lock_r)
            LOCK_RUNNING:
                if (trip)
                    lock_nxt = LOCK_TRIPPED;
            LOCK_TRIPPED:
                if (flag_rd && !trip)
                    lock_nxt = LOCK_RUNNING;
            default:
                lock_nxt = LOCK_RUNNING;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            lock_r <= LOCK_RUNNING;
            shutdown_r <= 1'b0;
        end
        else if (i_ce)
        begin
            lock_r <= lock_nxt;
            shutdown_r <= (lock_nxt == LOCK_TRIPPED);
        end
    end

    // Boost gating; the comparator carries the 1 V hysteresis, so release follows it
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            gate_r <= 1'b0;
        else if (i_ce)
            gate_r <= dev_en && !trip && lock_r == LOCK_RUNNING
                      && !ovp_s
                      && !tsd_s;
    end

    // Cycle-by-cycle limit; set wins over the period restart
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            sw_off_r <= 1'b0;
        else if (i_ce)
        begin
            if (ocp_s)
                sw_off_r <= 1'b1;
            else if (i_period_start)
                sw_off_r <= 1'b0;
        end
    end

    // Read data, one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rdata_r <= 8'h00;
        else if (i_ce && i_reg_rd)
        begin
            case (i_reg_addr)
                ADDR_ENABLE: rdata_r <= enable_r;
                ADDR_BOOST: rdata_r <= boost_r;
                ADDR_BRT_LSB: rdata_r <= brt_lsb_r;
                ADDR_BRT_MSB: rdata_r <= brt_msb_r;
                ADDR_FAULT_CTRL: rdata_r <= ctrl_r;
                ADDR_FAULT_FLAGS: rdata_r <= flags_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_boost_enable = gate_r;
    assign o_low_side_switch_off = sw_off_r;
    assign o_overvoltage_level = boost_r[BOOST_OVP_LSB +: 2];
    assign o_overcurrent_level = boost_r[BOOST_OCP_LSB +: 2];
    assign o_string_enable = enable_r[EN_STRING_MSB:EN_STRING_LSB];
    assign o_device_shutdown = shutdown_r;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence ocp_trip_s;
        i_ce && set_ocp;
    endsequence

    sequence flag_locked_s;
        i_ce && lock_r == LOCK_TRIPPED && en_wr && !flag_rd;
    endsequence

    a_ovp_gate_off: assert property (i_ce && ovp_s |=> !o_boost_enable)
        else $error("boost enabled during overvoltage");
    a_tsd_gate_off: assert property (i_ce && tsd_s |=> !o_boost_enable)
        else $error("boost enabled during overtemperature");
    a_ovp_long_flag: assert property (i_ce && ovp_long_evt |=> flags_r[FLAG_OVP])
        else $error("long overvoltage did not set flag");
    a_open_both_flags: assert property (i_ce && set_open |=> flags_r[FLAG_OPEN] && flags_r[FLAG_OVP])
        else $error("open string did not set both flags");
    a_ocp_blanked: assert property (i_ce && brt_change |=> blanking && !ocp_evt)
        else $error("overcurrent counted while blanked");
    a_ocp_flag_set: assert property (ocp_trip_s |=> flags_r[FLAG_OCP])
        else $error("overcurrent flag not set");
    a_lock_refuse_en: assert property (flag_locked_s |=> !enable_r[EN_DEVICE_BIT])
        else $error("re-enable accepted while locked");
    a_report_only: assert property (i_ce && lock_r == LOCK_RUNNING && (set_vec[FLAG_OVP] || set_ocp || set_tsd)
        && (ctrl_r & FAULT_CTRL_MASK) == 8'h00 |=> lock_r == LOCK_RUNNING && !o_device_shutdown)
        else $error("shutdown without control bit");
    a_read_clears: assert property (i_ce && flag_rd && set_vec == FLAGS_RST && lock_r == LOCK_TRIPPED
        |=> flags_r == FLAGS_RST && lock_r == LOCK_RUNNING && !o_device_shutdown)
        else $error("flag read did not clear flags and lock");
    a_switch_off: assert property (i_ce && ocp_s |=> o_low_side_switch_off)
        else $error("low-side switch not cut on overcurrent");

endmodule

// ### verification/backlight_fault_supervisor_tb.sv
/*
 * Self-checking bench for the backlight fault supervisor: register port, thermal,
 * overvoltage, open, short and overcurrent paths.
 * Assumes shortened timing parameters and comparator levels driven on the falling edge.
 */
`timescale 1ns/1ps
module backlight_fault_supervisor_tb;
    import supervisor_pkg::*;
    logic i_clk, i_reset_n, i_ce, i_ovp_cmp, i_ocp_cmp, i_tsd_cmp, i_period_start, i_reg_wr, i_reg_rd;
    logic [2:0] i_headroom_low, i_short_cmp, o_string_enable;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic o_boost_enable, o_low_side_switch_off, o_device_shutdown;
    logic [1:0] o_overvoltage_level, o_overcurrent_level;
    int fail_count = 0, samples_checked = 0, cycles = 0;

    // Short counts keep the whole run under a thousand cycles
    backlight_fault_supervisor #(.TICK_DIV(2), .OVP_PERSIST(10), .OCP_WINDOW(8), .OCP_BLANK(5)) dut_u (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_ovp_cmp(i_ovp_cmp),
        .i_headroom_low(i_headroom_low), .i_short_cmp(i_short_cmp), .i_ocp_cmp(i_ocp_cmp),
        .i_tsd_cmp(i_tsd_cmp), .i_period_start(i_period_start), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .o_boost_enable(o_boost_enable), .o_low_side_switch_off(o_low_side_switch_off),
        .o_overvoltage_level(o_overvoltage_level), .o_overcurrent_level(o_overcurrent_level),
        .o_string_enable(o_string_enable), .o_device_shutdown(o_device_shutdown));

    // Clock
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic close_out();
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, well above the sum of all scenarios
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // Strobes last one cycle; every call starts and ends on a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        cyc(1);
        i_reg_wr = 1'b0;
    endtask

    // Read data is registered, so it is judged one edge after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        cyc(1);
        i_reg_rd = 1'b0;
        cyc(1);
        chk(o_reg_rdata, exp);
    endtask

    task automatic reset_values();
        chk({6'h00, o_overvoltage_level}, 8'h03);
        chk({6'h00, o_overcurrent_level}, 8'h03);
        chk({5'h00, o_string_enable}, 8'h07);
        rd(ADDR_FAULT_CTRL, FAULT_CTRL_RST);
        rd(8'h20, 8'h00);
        wr(ADDR_FAULT_FLAGS, 8'hFF);
        rd(ADDR_FAULT_FLAGS, 8'h00);
        // A write made while the clock enable is low must not land
        i_ce = 1'b0;
        wr(ADDR_BOOST, 8'h00);
        i_ce = 1'b1;
        chk({6'h00, o_overvoltage_level}, 8'h03);
        wr(ADDR_BOOST, 8'h26);
        cyc(1);
        chk({6'h00, o_overvoltage_level}, 8'h01);
        chk({6'h00, o_overcurrent_level}, 8'h02);
    endtask

    // Thermal trip with or without the lock; without it boost restarts by itself
    task automatic thermal(input logic [7:0] ctrl);
        wr(ADDR_FAULT_CTRL, ctrl);
        i_tsd_cmp = 1'b1;
        cyc(5);
        chk({7'h00, o_boost_enable}, 8'h00);
        chk({7'h00, o_device_shutdown}, {7'h00, ctrl[2]});
        i_tsd_cmp = 1'b0;
        cyc(5);
        chk({7'h00, o_boost_enable}, {7'h00, ~ctrl[2]});
        wr(ADDR_ENABLE, 8'h0F);
        cyc(1);
        rd(ADDR_ENABLE, ctrl[2] ? 8'h0E : 8'h0F);
        rd(ADDR_FAULT_FLAGS, 8'h04);
        cyc(2);
        chk({7'h00, o_device_shutdown}, 8'h00);
        wr(ADDR_ENABLE, 8'h0F);
        cyc(5);
        chk({7'h00, o_boost_enable}, 8'h01);
        rd(ADDR_FAULT_FLAGS, 8'h00);
    endtask

    // Long overvoltage; open flag joins only if the low string is enabled
    task automatic ovp_hold(input logic [7:0] en, input logic [7:0] exp);
        wr(ADDR_ENABLE, en);
        wr(ADDR_BRT_LSB, 8'h07);
        wr(ADDR_BRT_MSB, 8'hFF);
        i_headroom_low = 3'b010;
        i_ovp_cmp = 1'b1;
        cyc(5);
        chk({7'h00, o_boost_enable}, 8'h00);
        cyc(40);
        i_ovp_cmp = 1'b0;
        i_headroom_low = 3'b000;
        cyc(5);
        chk({7'h00, o_boost_enable}, 8'h01);
        rd(ADDR_FAULT_FLAGS, exp);
    endtask

    task automatic ovp_count();
        i_headroom_low = 3'b001;
        repeat (3)
        begin
            i_ovp_cmp = 1'b1;
            cyc(4);
            i_ovp_cmp = 1'b0;
            cyc(4);
        end
        i_headroom_low = 3'b000;
        rd(ADDR_FAULT_FLAGS, 8'h11);
    endtask

    // Short test on string one alone, as software runs it; the flag outlives the short
    task automatic short_string();
        wr(ADDR_ENABLE, 8'h03);
        wr(ADDR_FAULT_CTRL, 8'h01);
        wr(ADDR_BRT_LSB, 8'h07);
        wr(ADDR_BRT_MSB, 8'hFF);
        chk({5'h00, o_string_enable}, 8'h01);
        i_short_cmp = 3'b001;
        cyc(5);
        rd(ADDR_FAULT_FLAGS, 8'h08);
        wr(ADDR_ENABLE, 8'h00);
        i_short_cmp = 3'b000;
        cyc(5);
        rd(ADDR_FAULT_FLAGS, 8'h08);
        rd(ADDR_FAULT_FLAGS, 8'h00);
        wr(ADDR_ENABLE, 8'h0F);
    endtask

    // A rising hit every six cycles gives at least two per 16-cycle window
    task automatic ocp_burst(input logic [7:0] ctrl);
        wr(ADDR_FAULT_CTRL, ctrl);
        wr(ADDR_BRT_MSB, 8'h80);
        i_ocp_cmp = 1'b1;
        cyc(4);
        chk({7'h00, o_low_side_switch_off}, 8'h01);
        // The synchroniser still shows the hit for two edges, so the period restarts later
        i_ocp_cmp = 1'b0;
        cyc(3);
        chk({7'h00, o_low_side_switch_off}, 8'h01);
        i_period_start = 1'b1;
        cyc(1);
        i_period_start = 1'b0;
        chk({7'h00, o_low_side_switch_off}, 8'h00);
        repeat (40)
        begin
            i_ocp_cmp = 1'b1;
            cyc(3);
            i_ocp_cmp = 1'b0;
            cyc(3);
        end
        chk({7'h00, o_device_shutdown}, {7'h00, ctrl[1]});
        rd(ADDR_FAULT_FLAGS, 8'h02);
        wr(ADDR_ENABLE, 8'h0F);
        cyc(5);
        chk({7'h00, o_device_shutdown}, 8'h00);
    endtask

    // Main sequence
    initial
    begin
        {i_ce, i_reset_n} = 2'b10;
        {i_ovp_cmp, i_ocp_cmp, i_tsd_cmp, i_period_start, i_reg_wr, i_reg_rd} = 6'h00;
        {i_headroom_low, i_short_cmp} = 6'h00;
        {i_reg_addr, i_reg_wdata} = 16'h0000;
        cyc(10);
        i_reset_n = 1'b1;
        cyc(6);
        reset_values();
        thermal(8'h00);
        thermal(8'h04);
        ovp_hold(8'h0B, 8'h01);
        ovp_hold(8'h0F, 8'h11);
        ovp_count();
        short_string();
        ocp_burst(8'h00);
        ocp_burst(8'h02);
        close_out();
    end
endmodule
